// *** core/sync_ptp_core.sv ***
// sync source selection, ptp slave exchange and end-to-end transparent clock
// assumes a packet parser on i_clk giving pulses at the frame reference point
//
// Chosen here: the address map and register access over Wishbone.
`include "sync_ptp_params.svh"

// What this block does
// - frequency reference from one interface only
// - source table holds at most eight sources
// - one active source drives frequency outputs
// - switch after candidate stable holdoff seconds, at once if active source is lost
// - holdoff resets zero; zero switches at once
// - slave stamps sync arrival as t2
// - t1 from sync or follow-up message
// - slave sends delay request, stamps t3
// - offset is half of difference
// - path delay is half of sum
// - timestamps captured in hardware
// - accept unicast and multicast ptp
// - act as end-to-end transparent clock
// - forward only, never terminate timing
// - adjust sync/delay request by residency
// - add residency into 64-bit correction field
// - residency includes radio and switch delay
// - ptp mapped to highest priority queue
// - best quality, then highest priority wins
module sync_ptp_core #(
   parameter int          NSRC       = 8,
   parameter logic [31:0] SEC_CYCLES = 32'(`SEC_NS / `CLK_NS)
) (
   // clock, reset, enable
   input  wire logic                     i_clk,
   input  wire logic                     i_rstn,
   input  wire logic                     i_ce,
   // wishbone slave
   input  wire logic                     i_wb_cyc,
   input  wire logic                     i_wb_stb,
   input  wire logic                     i_wb_we,
   input  wire logic [7:0]               i_wb_adr,
   input  wire logic [31:0]              i_wb_dat,
   input  wire logic [3:0]               i_wb_sel,
   output logic      [31:0]              o_wb_dat,
   output logic                          o_wb_ack,
   // source pins
   input  wire logic [NSRC-1:0]          i_src_ok,
   input  wire logic [NSRC-1:0]          i_src_ref,
   output logic      [NSRC-1:0]          o_src_act,
   output logic      [NSRC-1:0]          o_freq_out,
   // local ptp receive and transmit
   input  wire logic                     i_rx_ptp,
   input  wire sync_ptp_pkg::msg_t       i_rx_type,
   input  wire logic                     i_rx_two_step,
   input  wire logic                     i_rx_mcast,
   input  wire logic                     i_rx_ucast_hit,
   input  wire logic [63:0]              i_rx_ts,
   output logic                          o_dreq_send,
   input  wire logic                     i_tx_sof,
   // forwarded ptp traffic
   input  wire logic                     i_fw_ing,
   input  wire sync_ptp_pkg::msg_t       i_fw_type,
   input  wire logic                     i_fw_egr,
   input  wire logic [63:0]              i_fw_corr,
   input  wire logic [31:0]              i_radio_dly,
   output logic      [63:0]              o_fw_corr,
   output logic                          o_fw_corr_vld,
   output logic                          o_tc_busy,
   output logic      [2:0]               o_ptp_queue
);
   import sync_ptp_pkg::*;

   function automatic logic [63:0] half_s(input logic [63:0] v);
      half_s = {v[63], v[63:1]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers and bus
   logic [3:0]  ctrl_ff;
   logic [15:0] hold_ff;
   logic [11:0] cfg_ff [NSRC];
   logic [63:0] off_ff, dly_ff;
   logic        res_vld_ff;
   logic [2:0]  act_ff;
   logic        act_vld_ff;
   slave_st_t   st_ff;
   logic        wr_req;
   logic        dreq_go;

   assign wr_req  = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_ce;
   assign dreq_go = wr_req & (i_wb_adr == `ADR_CTRL) & i_wb_sel[0] & i_wb_dat[`CTRL_DREQ];

   // ack one cycle after the request, dropped the next cycle
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_wb_ack <= 1'b0;
      end else if (i_ce) begin
         o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_ff <= 4'h0;
         hold_ff <= `HOLD_RST;
         for (int i = 0; i < NSRC; i++) cfg_ff[i] <= 12'h000;
      end else if (wr_req) begin
         if (i_wb_adr == `ADR_CTRL && i_wb_sel[0]) ctrl_ff <= i_wb_dat[3:0] & 4'hb;
         if (i_wb_adr == `ADR_HOLD) begin
            if (i_wb_sel[0]) hold_ff[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) hold_ff[15:8] <= i_wb_dat[15:8];
         end
         // only eight table slots exist, others are unmapped
         for (int i = 0; i < NSRC; i++) begin
            if (i_wb_adr == `ADR_SRC0 + 8'(4 * i)) begin
               if (i_wb_sel[0]) cfg_ff[i][7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) cfg_ff[i][11:8] <= i_wb_dat[11:8];
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_wb_dat <= 32'h0;
      end else if (i_ce) begin
         o_wb_dat <= 32'h0;
         unique case (i_wb_adr)
            `ADR_CTRL:   o_wb_dat <= {28'h0, ctrl_ff};
            `ADR_HOLD:   o_wb_dat <= {16'h0, hold_ff};
            `ADR_STAT:   o_wb_dat <= {22'h0, st_ff, res_vld_ff, act_vld_ff, act_ff};
            `ADR_OFF_LO: o_wb_dat <= off_ff[31:0];
            `ADR_OFF_HI: o_wb_dat <= off_ff[63:32];
            `ADR_DLY_LO: o_wb_dat <= dly_ff[31:0];
            `ADR_DLY_HI: o_wb_dat <= dly_ff[63:32];
            default: begin
               for (int i = 0; i < NSRC; i++)
                  if (i_wb_adr == `ADR_SRC0 + 8'(4 * i)) o_wb_dat <= {20'h0, cfg_ff[i]};
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // source selection
   logic [NSRC-1:0] ok_s1, ok_s2, ref_s1, ref_s2;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ok_s1  <= '0;
         ok_s2  <= '0;
         ref_s1 <= '0;
         ref_s2 <= '0;
      end else if (i_ce) begin
         ok_s1  <= i_src_ok;
         ok_s2  <= ok_s1;
         ref_s1 <= i_src_ref;
         ref_s2 <= ref_s1;
      end
   end

   logic [2:0] best;
   logic       best_vld;
   always_comb begin
      best     = 3'h0;
      best_vld = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         // quality first, priority breaks ties, lower index on full tie
         if (cfg_ff[i][`CFG_EN] && ok_s2[i] &&
             (!best_vld || {cfg_ff[i][7:4], cfg_ff[i][11:8]} > {cfg_ff[best][7:4], cfg_ff[best][11:8]})) begin
            best     = 3'(i);
            best_vld = 1'b1;
         end
      end
   end

   logic [31:0] tick_ff;
   logic        sec_tick;
   logic [2:0]  cand_ff;
   logic [15:0] stab_ff;
   logic        act_ok;
   assign sec_tick = (tick_ff == SEC_CYCLES - 32'd1);
   assign act_ok   = act_vld_ff & ok_s2[act_ff] & cfg_ff[act_ff][`CFG_EN];

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tick_ff <= 32'h0;
      end else if (i_ce) begin
         tick_ff <= sec_tick ? 32'h0 : tick_ff + 32'd1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         act_ff     <= 3'h0;
         act_vld_ff <= 1'b0;
         cand_ff    <= 3'h0;
         stab_ff    <= 16'h0;
      end else if (i_ce) begin
         if (!best_vld) begin
            act_vld_ff <= act_ok;
            stab_ff    <= 16'h0;
         end else if (act_ok && best == act_ff) begin
            stab_ff <= 16'h0;
         end else if (!act_ok || hold_ff == 16'h0 ||
                      (best == cand_ff && stab_ff >= hold_ff)) begin
            // lost reference or zero holdoff switches at once
            act_ff     <= best;
            act_vld_ff <= 1'b1;
            stab_ff    <= 16'h0;
         end else if (best != cand_ff) begin
            // a new or flapping candidate starts its wait again
            cand_ff <= best;
            stab_ff <= 16'h0;
         end else if (sec_tick) begin
            stab_ff <= stab_ff + 16'd1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_src_act  <= '0;
         o_freq_out <= '0;
      end else if (i_ce) begin
         for (int i = 0; i < NSRC; i++) begin
            o_src_act[i] <= act_vld_ff && act_ff == 3'(i);
            // the active source is never looped back onto itself
            o_freq_out[i] <= act_vld_ff && act_ff != 3'(i) && cfg_ff[i][`CFG_OUT] && ref_s2[act_ff];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hardware time of day and ptp slave
   logic [63:0] tod_ff, t1_ff, t2_ff, t3_ff;
   logic        rx_ok;
   logic [63:0] d1, d2;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tod_ff <= 64'h0;
      end else if (i_ce) begin
         tod_ff <= tod_ff + `CLK_NS;
      end
   end

   assign rx_ok = i_rx_ptp & ctrl_ff[`CTRL_SLAVE] & (i_rx_mcast | i_rx_ucast_hit);
   assign d1    = t2_ff - t1_ff;
   assign d2    = i_rx_ts - t3_ff;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_ff       <= SL_IDLE;
         t1_ff       <= 64'h0;
         t2_ff       <= 64'h0;
         t3_ff       <= 64'h0;
         off_ff      <= 64'h0;
         dly_ff      <= 64'h0;
         res_vld_ff  <= 1'b0;
         o_dreq_send <= 1'b0;
      end else if (i_ce) begin
         o_dreq_send <= 1'b0;
         if (rx_ok && i_rx_type == MSG_SYNC && st_ff != SL_TX) begin
            t2_ff <= tod_ff;
            t1_ff <= i_rx_ts;
            st_ff <= i_rx_two_step ? SL_FU : SL_HAVE;
         end else begin
            unique case (st_ff)
               SL_IDLE: st_ff <= SL_IDLE;
               SL_FU: begin
                  if (rx_ok && i_rx_type == MSG_FU) begin
                     t1_ff <= i_rx_ts;
                     st_ff <= SL_HAVE;
                  end
               end
               SL_HAVE: begin
                  if (dreq_go) begin
                     o_dreq_send <= 1'b1;
                     st_ff       <= SL_TX;
                  end
               end
               SL_TX: begin
                  if (i_tx_sof) begin
                     t3_ff <= tod_ff;
                     st_ff <= SL_RESP;
                  end
               end
               SL_RESP: begin
                  if (rx_ok && i_rx_type == MSG_DRESP) begin
                     // t4 arrives from the master in the response
                     off_ff     <= half_s(d1 - d2);
                     dly_ff     <= half_s(d1 + d2);
                     res_vld_ff <= 1'b1;
                     st_ff      <= SL_IDLE;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transparent clock: one event message in flight between ingress and egress
   logic [63:0] ing_ff;
   logic [63:0] resid;
   logic        fw_evt;
   assign fw_evt = i_fw_ing & ctrl_ff[`CTRL_TC] & (i_fw_type == MSG_SYNC || i_fw_type == MSG_DREQ);
   assign resid  = tod_ff - ing_ff + {32'h0, i_radio_dly};

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ing_ff        <= 64'h0;
         o_tc_busy     <= 1'b0;
         o_fw_corr     <= 64'h0;
         o_fw_corr_vld <= 1'b0;
      end else if (i_ce) begin
         o_fw_corr_vld <= 1'b0;
         if (o_tc_busy && i_fw_egr) begin
            // correction is in ns scaled by 2^16, message is passed on
            o_fw_corr     <= i_fw_corr + {resid[63-`CORR_SHIFT:0], 16'h0};
            o_fw_corr_vld <= 1'b1;
            o_tc_busy     <= 1'b0;
         end else if (fw_evt && !o_tc_busy) begin
            ing_ff    <= tod_ff;
            o_tc_busy <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ptp_queue <= 3'h0;
      end else if (i_ce) begin
         o_ptp_queue <= ctrl_ff[`CTRL_PRIO] ? `TOP_QUEUE : 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_one_active: assert property (@(posedge i_clk) disable iff (!i_rstn)
      $onehot0(o_src_act)) else $error("more than one active source");
   chk_no_self_out: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (o_freq_out & o_src_act) == '0) else $error("active source drives itself");
   chk_hold_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_ce && hold_ff == 16'h0 && best_vld && best != act_ff |=> act_ff == $past(best))
      else $error("zero holdoff did not switch");
   chk_hold_wait: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_ce && act_ok && hold_ff != 16'h0 && stab_ff < hold_ff |=> act_ff == $past(act_ff))
      else $error("switched before holdoff");
   chk_t2_stamp: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_ce && rx_ok && i_rx_type == MSG_SYNC && st_ff != SL_TX |=> t2_ff == $past(tod_ff))
      else $error("t2 not stamped");
   chk_dreq_t3: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_dreq_send |-> st_ff == SL_TX) else $error("delay request without wait");
   chk_delay_calc: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_ce && st_ff == SL_RESP && rx_ok && i_rx_type == MSG_DRESP |=> res_vld_ff && dly_ff == half_s($past(d1) + $past(d2)))
      else $error("path delay wrong");
   chk_corr_add: assert property (@(posedge i_clk) disable iff (!i_rstn)
      i_ce && o_tc_busy && i_fw_egr |=> o_fw_corr_vld ##1 !o_fw_corr_vld || !i_ce)
      else $error("correction pulse wrong");
   chk_ack_pulse: assert property (@(posedge i_clk) disable iff (!i_rstn)
      o_wb_ack && i_ce |=> !o_wb_ack) else $error("ack held too long");
endmodule

// *** common/sync_ptp_params.svh ***
// constants for the sync source selector and ptp timing block
// assumes a 125 MHz system clock and a 32-bit wishbone register bus
`ifndef SYNC_PTP_PARAMS_SVH
`define SYNC_PTP_PARAMS_SVH
`define CLK_NS        64'd8
`define SEC_NS        64'd1000000000
`define HOLD_RST      16'h0000
`define ADR_CTRL      8'h00
`define ADR_HOLD      8'h04
`define ADR_STAT      8'h08
`define ADR_OFF_LO    8'h10
`define ADR_OFF_HI    8'h14
`define ADR_DLY_LO    8'h18
`define ADR_DLY_HI    8'h1c
`define ADR_SRC0      8'h20
`define CTRL_SLAVE    0
`define CTRL_TC       1
`define CTRL_DREQ     2
`define CTRL_PRIO     3
`define CFG_EN        0
`define CFG_OUT       1
`define CFG_QL        4
`define CFG_PR        8
`define CORR_SHIFT    16
`define TOP_QUEUE     3'h7
`endif

// *** common/sync_ptp_pkg.sv ***
// types shared by the sync source selector and ptp timing block
// assumes nothing beyond a systemverilog compiler
package sync_ptp_pkg;
   typedef enum logic [3:0] {
      MSG_SYNC  = 4'h0,
      MSG_DREQ  = 4'h1,
      MSG_FU    = 4'h8,
      MSG_DRESP = 4'h9
   } msg_t;
   typedef enum logic [4:0] {
      SL_IDLE = 5'b00001,
      SL_FU   = 5'b00010,
      SL_HAVE = 5'b00100,
      SL_TX   = 5'b01000,
      SL_RESP = 5'b10000
   } slave_st_t;
endpackage

// *** dv/ptp_master_model.sv ***
// ptp master partner: sends sync, follow-up and delay response frames
// assumes the slave pulses i_dreq_send and stamps t3 on o_tx_sof
module ptp_master_model (
   input  wire logic          i_clk,
   input  wire logic          i_dreq_send,
   output logic               o_rx_ptp,
   output sync_ptp_pkg::msg_t o_rx_type,
   output logic               o_rx_two_step,
   output logic               o_rx_mcast,
   output logic               o_rx_ucast_hit,
   output logic [63:0]        o_rx_ts,
   output logic               o_tx_sof
);
   timeunit 1ns;
   timeprecision 1ps;
   import sync_ptp_pkg::*;
   int          gap = 1;
   int          n_resp = 0;
   logic [63:0] t4_add = 0;
   logic [63:0] t1 = 0;
   time         sync_t;
   time         sof_t;
   // the timestamp is inverted between frames so no stale value can pass
   task automatic frame(input msg_t ty, input logic [63:0] ts, input logic two, mc, uc);
      @(posedge i_clk);
      o_rx_ptp       <= 1'b1;
      o_rx_type      <= ty;
      o_rx_ts        <= ts;
      o_rx_two_step  <= two;
      o_rx_mcast     <= mc;
      o_rx_ucast_hit <= uc;
      @(posedge i_clk);
      o_rx_ptp <= 1'b0;
      o_rx_ts  <= ~ts;
   endtask
   task automatic send_sync(input logic [63:0] ts1, input logic two, mc, uc);
      frame(MSG_SYNC, two ? ~ts1 : ts1, two, mc, uc);
      sync_t = $time;
      t1 = ts1;
      if (two)
         frame(MSG_FU, ts1, two, mc, uc);
   endtask
   initial begin
      o_rx_ptp = 1'b0;
      o_rx_type = MSG_SYNC;
      o_rx_two_step = 1'b0;
      o_rx_mcast = 1'b0;
      o_rx_ucast_hit = 1'b0;
      o_rx_ts = 64'h0;
      o_tx_sof = 1'b0;
      forever begin
         @(posedge i_clk);
         if (i_dreq_send === 1'b1) begin
            repeat (gap) @(posedge i_clk);
            o_tx_sof <= 1'b1;
            @(posedge i_clk);
            o_tx_sof <= 1'b0;
            sof_t = $time;
            frame(MSG_DRESP, t1 + t4_add, 1'b0, o_rx_mcast, o_rx_ucast_hit);
            n_resp++;
         end
      end
   end
endmodule

// *** dv/sync_source_ptp_transparent_clock_test.sv ***
// self-checking bench: source selection, holdoff, ptp slave, transparent clock
// assumes the design's time base counts ns at 8 per cycle
`include "sync_ptp_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module sync_source_ptp_transparent_clock_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sync_ptp_pkg::*;
   logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, fw_ing = 0, fw_egr = 0, ce = 1;
   logic [3:0]  sel = 0;
   logic [7:0]  adr = 0, ok = 0, sref = 0, act, fout;
   logic [31:0] wdat = 0, rdat, radio = 0, q, seed = 32'h988c79dd;
   logic [63:0] fcorr = 0, ocorr, rts, t1v, fcv, dly, off, pt1, pd, poff;
   logic        ack, dreq, rxp, two, mc, uc, sof, vld, busy;
   logic [2:0]  queue;
   logic [11:0] cfg [8];
   msg_t        rty, fty = MSG_SYNC;
   int          miscompares = 0, n_checks = 0, n;
   time         ti, te, pst;
   sync_ptp_core #(.NSRC(8), .SEC_CYCLES(32'd20)) sync_ptp_core_i (
      .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_src_ok(ok), .i_src_ref(sref), .o_src_act(act), .o_freq_out(fout), .i_rx_ptp(rxp),
      .i_rx_type(rty), .i_rx_two_step(two), .i_rx_mcast(mc), .i_rx_ucast_hit(uc), .i_rx_ts(rts),
      .o_dreq_send(dreq), .i_tx_sof(sof), .i_fw_ing(fw_ing), .i_fw_type(fty), .i_fw_egr(fw_egr),
      .i_fw_corr(fcorr), .i_radio_dly(radio), .o_fw_corr(ocorr), .o_fw_corr_vld(vld),
      .o_tc_busy(busy), .o_ptp_queue(queue));
   ptp_master_model ptp_master_model_i (
      .i_clk(clk), .i_dreq_send(dreq), .o_rx_ptp(rxp), .o_rx_type(rty), .o_rx_two_step(two),
      .o_rx_mcast(mc), .o_rx_ucast_hit(uc), .o_rx_ts(rts), .o_tx_sof(sof));
   initial begin
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // best enabled healthy source: quality first, then priority, low index on ties
   function automatic logic [7:0] best();
      int b;
      b = -1;
      for (int i = 0; i < 8; i++)
         if (cfg[i][0] && ok[i] && (b < 0 || {cfg[i][7:4], cfg[i][11:8]} > {cfg[b][7:4], cfg[b][11:8]}))
            b = i;
      return (b < 0) ? 8'h00 : 8'h01 << b;
   endfunction
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      // no local limit: only the watchdog ends a bus wait
      do
         @(posedge clk);
      while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic results();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      results();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      wb(0, `ADR_HOLD, 0);
      `CHK(q, 32'h0)
      wb(1, 8'hfc, 32'hffffffff);
      wb(0, 8'hfc, 0);
      `CHK(q, 32'h0)
      for (int t = 0; t < 6; t++) begin
         for (int i = 0; i < 8; i++) begin
            cfg[i] = 12'(rnd()) & 12'hff3;
            wb(1, 8'h20 + 8'(4 * i), {20'h0, cfg[i]});
         end
         ok <= 8'(rnd());
         sref <= 8'(rnd());
         repeat (8) @(posedge clk);
         `CHK(act, best())
         `CHK(fout, {8{|(sref & best())}} & ~best() & {cfg[7][1], cfg[6][1], cfg[5][1], cfg[4][1], cfg[3][1], cfg[2][1], cfg[1][1], cfg[0][1]})
      end
      wb(0, 8'h3c, 0);
      `CHK(q, {20'h0, cfg[7]})
      wb(0, 8'h40, 0);
      `CHK(q, 32'h0)
      for (int i = 0; i < 8; i++)
         wb(1, 8'h20 + 8'(4 * i), (i == 0) ? 32'h153 : (i == 1) ? 32'h193 : 32'h0);
      ok <= 8'h01;
      wb(1, `ADR_HOLD, 32'h2);
      repeat (8) @(posedge clk);
      ok <= 8'h03;
      // checked before a second tick can complete the wait, flapped before it too
      repeat (15) @(posedge clk);
      `CHK(act, 8'h01)
      ok <= 8'h01;
      @(posedge clk);
      ok <= 8'h03;
      repeat (15) @(posedge clk);
      `CHK(act, 8'h01)
      repeat (60) @(posedge clk);
      `CHK(act, 8'h02)
      ok <= 8'h01;
      repeat (6) @(posedge clk);
      `CHK(act, 8'h01)
      wb(1, `ADR_HOLD, 32'h0);
      ok <= 8'h03;
      repeat (6) @(posedge clk);
      `CHK(act, 8'h02)
      // a low enable freezes the synchronisers and the selection
      ce <= 1'b0;
      ok <= 8'h01;
      repeat (8) @(posedge clk);
      `CHK(act, 8'h02)
      ce <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(act, 8'h01)
      // slave: a sync for neither address must leave the exchange idle
      wb(1, `ADR_CTRL, 32'h1);
      ptp_master_model_i.send_sync(64'h10, 1'b0, 1'b0, 1'b0);
      wb(1, `ADR_CTRL, 32'h5);
      repeat (20) @(posedge clk);
      wb(0, `ADR_STAT, 0);
      `CHK(q[9:5], 5'b00001)
      `CHK(ptp_master_model_i.n_resp, 0)
      `CHK(queue, 3'h0)
      for (int k = 0; k < 4; k++) begin
         ptp_master_model_i.gap = 1 + 8 * k;
         ptp_master_model_i.t4_add = 64'(rnd() & 32'hffe) + 64'd40000;
         // t1 kept near local time so the halved difference stays in signed range
         t1v = 64'(rnd() & 32'hfffe);
         ptp_master_model_i.send_sync(t1v, k[0], k[1], ~k[1]);
         repeat (2) @(posedge clk);
         wb(1, `ADR_CTRL, 32'h5);
         n = 0;
         while (ptp_master_model_i.n_resp == k && n < 200) begin
            @(posedge clk);
            n++;
         end
         repeat (3) @(posedge clk);
         wb(0, `ADR_DLY_LO, 0);
         dly[31:0] = q;
         wb(0, `ADR_DLY_HI, 0);
         dly[63:32] = q;
         wb(0, `ADR_OFF_LO, 0);
         off[31:0] = q;
         wb(0, `ADR_OFF_HI, 0);
         off[63:32] = q;
         `CHK(dly, (ptp_master_model_i.t4_add - 64'(ptp_master_model_i.sof_t - ptp_master_model_i.sync_t)) >> 1)
         if (k > 0)
            `CHK(off - poff, 64'(ptp_master_model_i.sync_t - pst) - (t1v - pt1) - (dly - pd))
         poff = off;
         pd = dly;
         pt1 = t1v;
         pst = ptp_master_model_i.sync_t;
      end
      wb(1, `ADR_CTRL, 32'ha);
      @(posedge clk);
      `CHK(queue, `TOP_QUEUE)
      for (int k = 0; k < 7; k++) begin
         fcv = {rnd(), rnd()};
         radio <= rnd() & 32'hffff;
         @(posedge clk);
         fw_ing <= 1'b1;
         fty <= (k == 6) ? MSG_FU : k[0] ? MSG_DREQ : MSG_SYNC;
         @(posedge clk);
         fw_ing <= 1'b0;
         ti = $time;
         @(posedge clk);
         `CHK(busy, k != 6)
         fw_ing <= 1'b1;
         @(posedge clk);
         fw_ing <= 1'b0;
         repeat (2 + (rnd() & 15)) @(posedge clk);
         fw_egr <= 1'b1;
         fcorr <= fcv;
         @(posedge clk);
         fw_egr <= 1'b0;
         fcorr <= ~fcv;
         te = $time;
         @(posedge clk);
         `CHK(vld, k != 6)
         if (k != 6)
            `CHK(ocorr, fcv + ((64'(te - ti) + 64'(radio)) << `CORR_SHIFT))
      end
      results();
   end
endmodule
